// File: logic/itc_consts.vh
// Constants for the interrupt controller with timers 0 and 1.
`ifndef ITC_CONSTS_VH
`define ITC_CONSTS_VH

// ============================================================
// Register indices; the APB byte address is four times the index.
`define ITC_IDX_TIMER_CONTROL 8'h88
`define ITC_IDX_TIMER_MODE 8'h89
`define ITC_IDX_TIMER0_LOW 8'h8A
`define ITC_IDX_TIMER1_LOW 8'h8B
`define ITC_IDX_TIMER0_HIGH 8'h8C
`define ITC_IDX_TIMER1_HIGH 8'h8D
`define ITC_IDX_IRQ_ENABLE 8'hA8
`define ITC_IDX_IRQ_PRIORITY 8'hB8
`define ITC_IDX_XIRQ_CONTROL 8'hC0
`define ITC_IDX_IRQ_STATUS 8'hC4

// ============================================================
// Reset values.
`define ITC_RST_BYTE 8'h00

// ============================================================
// Timer control field positions.
`define ITC_TC_XINT0_TYPE 0
`define ITC_TC_XINT0_FLAG 1
`define ITC_TC_XINT1_TYPE 2
`define ITC_TC_XINT1_FLAG 3
`define ITC_TC_T0_RUN 4
`define ITC_TC_T0_OVF 5
`define ITC_TC_T1_RUN 6
`define ITC_TC_T1_OVF 7

// Extra external interrupt control field positions.
`define ITC_XC_XINT2_TYPE 0
`define ITC_XC_XINT2_FLAG 1
`define ITC_XC_XINT2_EN 2
`define ITC_XC_XINT2_HIGH 3
`define ITC_XC_XINT3_TYPE 4
`define ITC_XC_XINT3_FLAG 5
`define ITC_XC_XINT3_EN 6
`define ITC_XC_XINT3_HIGH 7

// Master enable position in the enable register.
`define ITC_IE_GLOBAL 7

// ============================================================
// Vector of source n is n * VECTOR_STEP + VECTOR_BASE.
`define ITC_VECTOR_BASE 8'h03
`define ITC_VECTOR_STEP 8'h08

// Clocks per machine cycle.
`define ITC_MCYCLE_CLKS 8'd12

`endif

// File: logic/itc_irq_ctrl.v
// Eight-source two-level interrupt controller with timer/counters 0 and 1.
`timescale 1ns/1ps
`default_nettype none
`include "itc_consts.vh"
// ============================================================
// Summary of operation
// - Source n vectors to 8n+3: 03H for external 0 up to 3BH for external 3.
// - Within one level the lowest source number wins, external 0 first.
// - Enable bit 7 is a master enable; cleared, nothing is serviced.
// - Enable bits 0 to 5 gate the six standard sources; bit 6 unused.
// - Priority bits 0 to 5 mark standard sources high priority when set.
// - External 2 and 3 take enable and priority from the extra control register.
// - Extra control: bits 7..4 serve external 3, bits 3..0 external 2.
// - Extra external type bit set means falling edge, cleared means low level.
// - Extra external edge flag sets on edge and clears when serviced.
// - External 0 and 1 type bits select falling edge or low level.
// - External 0 and 1 edge flags set on edge, clear when processed.
// - Timer overflow flags set on overflow, clear when vectored.
// - Run bits start and stop timers 0 and 1.
// - Gate set: count only while run bit set and interrupt pin high.
// - Counter select clear counts machine cycles, set counts pin events.
// - Mode 00 is a 13-bit counter, mode 01 a 16-bit counter.
// - Mode 10 runs low byte 8-bit, reloaded from high byte on overflow.
// - Timer 0 mode 11 splits it; high byte uses timer 1 run and flag.
// - Timer 1 in mode 11 is held stopped.
// - Timer 2 request is raised by its overflow or capture/reload flag.
module itc_irq_ctrl #(
   parameter [7:0] MCYCLE_CLKS = `ITC_MCYCLE_CLKS
) (
   input wire REF_CLK,
   input wire RST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   input wire XINT0_PIN,
   input wire XINT1_PIN,
   input wire XINT2_PIN,
   input wire XINT3_PIN,
   input wire T0_COUNT_PIN,
   input wire T1_COUNT_PIN,
   input wire SERIAL_REQ,
   input wire TIMER2_OVERFLOW_FLAG,
   input wire TIMER2_CAPTURE_RELOAD_FLAG,
   output reg IRQ_REQ,
   output reg [7:0] IRQ_VECTOR,
   input wire IRQ_ACK,
   input wire IRQ_RETURN
);
   // ============================================================
   // Functions
   // Lowest set bit of an eight-bit request vector, with a valid flag.
   function [3:0] itc_first;
      input [7:0] req;
      integer k;
      begin
         itc_first = 4'h0;
         for (k = 7; k >= 0; k = k - 1) begin
            if (req[k]) begin
               itc_first = {1'b1, k[2:0]};
            end
         end
      end
   endfunction
   // One count step of a timer; returns {overflow, high byte, low byte}.
   function [16:0] itc_step;
      input [1:0] mode;
      input [7:0] tl;
      input [7:0] th;
      reg [13:0] w13;
      reg [16:0] w16;
      reg [8:0] w8;
      begin
         w13 = {1'b0, th, tl[4:0]} + 14'h0001;
         w16 = {1'b0, th, tl} + 17'h00001;
         w8 = {1'b0, tl} + 9'h001;
         case (mode)
            2'b00: itc_step = {w13[13], w13[12:5], tl[7:5], w13[4:0]};
            2'b01: itc_step = w16;
            2'b10: itc_step = {w8[8], th, (w8[8] ? th : w8[7:0])};
            default: itc_step = {w8[8], th, w8[7:0]};
         endcase
      end
   endfunction
   // Next value of an event flag; a hardware set wins over any clear.
   function itc_flag;
      input old;
      input edge_mode;
      input set;
      input level_req;
      input wr;
      input wbit;
      input clr;
      begin
         if (!edge_mode) begin
            itc_flag = level_req;
         end else begin
            itc_flag = old;
            if (wr) begin
               itc_flag = wbit;
            end
            if (clr) begin
               itc_flag = 1'b0;
            end
            if (set) begin
               itc_flag = 1'b1;
            end
         end
      end
   endfunction
   // True for every register index the slave answers.
   function itc_mapped;
      input [7:0] idx;
      begin
         case (idx)
            `ITC_IDX_TIMER_CONTROL, `ITC_IDX_TIMER_MODE, `ITC_IDX_TIMER0_LOW,
            `ITC_IDX_TIMER1_LOW, `ITC_IDX_TIMER0_HIGH, `ITC_IDX_TIMER1_HIGH,
            `ITC_IDX_IRQ_ENABLE, `ITC_IDX_IRQ_PRIORITY, `ITC_IDX_XIRQ_CONTROL,
            `ITC_IDX_IRQ_STATUS: itc_mapped = 1'b1;
            default: itc_mapped = 1'b0;
         endcase
      end
   endfunction

   // ============================================================
   // Pin synchronisers: three stages, a change counts once stages two and
   // three agree. Pins idle high, so the filtered copy resets high.
   wire [5:0] pin_raw = {T1_COUNT_PIN, T0_COUNT_PIN, XINT3_PIN, XINT2_PIN, XINT1_PIN,
      XINT0_PIN};
   reg [5:0] sy1;
   reg [5:0] sy2;
   reg [5:0] sy3;
   reg [5:0] pin_f;
   reg [5:0] pin_d;
   wire [5:0] pin_fall = pin_d & ~pin_f;
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sy1 <= 6'h3F;
         sy2 <= 6'h3F;
         sy3 <= 6'h3F;
         pin_d <= 6'h3F;
      end else begin
         sy1 <= pin_raw;
         sy2 <= sy1;
         sy3 <= sy2;
         pin_d <= pin_f;
      end
   end
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_filt
         always @(posedge REF_CLK or negedge RST_N) begin
            if (!RST_N) begin
               pin_f[g] <= 1'b1;
            end else if (sy2[g] == sy3[g]) begin
               pin_f[g] <= sy3[g];
            end
         end
      end
   endgenerate

   // ============================================================
   // Machine-cycle tick.
   reg [7:0] mc_cnt;
   wire tick = (mc_cnt == MCYCLE_CLKS - 8'd1);
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mc_cnt <= 8'h00;
      end else begin
         mc_cnt <= tick ? 8'h00 : mc_cnt + 8'h01;
      end
   end

   // ============================================================
   // Registers and APB decode. PREADY is always high: zero wait states.
   reg [7:0] timer_control;
   reg [7:0] timer_mode;
   reg [7:0] interrupt_enable;
   reg [7:0] interrupt_priority;
   reg [7:0] extra_external_irq_control;
   reg [7:0] timer0_low_byte;
   reg [7:0] timer0_high_byte;
   reg [7:0] timer1_low_byte;
   reg [7:0] timer1_high_byte;
   reg [1:0] in_service;
   reg [2:0] sel_idx;
   reg sel_high;
   wire [7:0] reg_idx = PADDR[9:2];
   wire addr_ok = itc_mapped(reg_idx) && (PADDR[11:10] == 2'b00) && (PADDR[1:0] == 2'b00);
   wire wr = PSEL && PENABLE && PWRITE && addr_ok;
   wire [7:0] wd = PWDATA[7:0];
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !addr_ok;

   // Read data is captured in the setup cycle, so flags read one cycle stale.
   reg [7:0] rd_mux;
   always @* begin
      case (reg_idx)
         `ITC_IDX_TIMER_CONTROL: rd_mux = timer_control;
         `ITC_IDX_TIMER_MODE: rd_mux = timer_mode;
         `ITC_IDX_TIMER0_LOW: rd_mux = timer0_low_byte;
         `ITC_IDX_TIMER1_LOW: rd_mux = timer1_low_byte;
         `ITC_IDX_TIMER0_HIGH: rd_mux = timer0_high_byte;
         `ITC_IDX_TIMER1_HIGH: rd_mux = timer1_high_byte;
         `ITC_IDX_IRQ_ENABLE: rd_mux = interrupt_enable & 8'hBF;
         `ITC_IDX_IRQ_PRIORITY: rd_mux = interrupt_priority & 8'h3F;
         `ITC_IDX_XIRQ_CONTROL: rd_mux = extra_external_irq_control;
         `ITC_IDX_IRQ_STATUS: rd_mux = {in_service, IRQ_REQ, sel_high, 1'b0, sel_idx};
         default: rd_mux = 8'h00;
      endcase
   end

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA <= 32'h00000000;
      end else if (PSEL && !PENABLE) begin
         PRDATA <= (addr_ok && !PWRITE) ? {24'h000000, rd_mux} : 32'h00000000;
      end
   end

   // ============================================================
   // Timers 0 and 1.
   wire [1:0] mode0 = timer_mode[1:0];
   wire [1:0] mode1 = timer_mode[5:4];
   wire t0_en = timer_control[`ITC_TC_T0_RUN] && (!timer_mode[3] || pin_f[0]);
   wire t1_en = timer_control[`ITC_TC_T1_RUN] && (!timer_mode[7] || pin_f[1]) &&
      (mode1 != 2'b11);
   wire inc0 = t0_en && (timer_mode[2] ? pin_fall[4] : tick);
   wire inc1 = t1_en && (timer_mode[6] ? pin_fall[5] : tick);
   wire split0 = (mode0 == 2'b11);
   wire inc_th0 = split0 && timer_control[`ITC_TC_T1_RUN] && tick;
   wire [16:0] step0 = itc_step(mode0, timer0_low_byte, timer0_high_byte);
   wire [16:0] step1 = itc_step(mode1, timer1_low_byte, timer1_high_byte);
   wire ovf0 = inc0 && step0[16];
   wire ovf_th0 = inc_th0 && (timer0_high_byte == 8'hFF);
   // While timer 0 is split, its high byte owns the timer 1 flag.
   wire ovf1 = (inc1 && step1[16] && !split0) || ovf_th0;

   reg [7:0] next_tl0;
   reg [7:0] next_th0;
   reg [7:0] next_tl1;
   reg [7:0] next_th1;
   always @* begin
      next_tl0 = inc0 ? step0[7:0] : timer0_low_byte;
      if (split0) begin
         next_th0 = inc_th0 ? timer0_high_byte + 8'h01 : timer0_high_byte;
      end else begin
         next_th0 = inc0 ? step0[15:8] : timer0_high_byte;
      end
      next_tl1 = inc1 ? step1[7:0] : timer1_low_byte;
      next_th1 = inc1 ? step1[15:8] : timer1_high_byte;
      if (wr && reg_idx == `ITC_IDX_TIMER0_LOW) begin
         next_tl0 = wd;
      end
      if (wr && reg_idx == `ITC_IDX_TIMER0_HIGH) begin
         next_th0 = wd;
      end
      if (wr && reg_idx == `ITC_IDX_TIMER1_LOW) begin
         next_tl1 = wd;
      end
      if (wr && reg_idx == `ITC_IDX_TIMER1_HIGH) begin
         next_th1 = wd;
      end
   end

   // ============================================================
   // Request collection and priority resolution.
   wire ack_go = IRQ_ACK && IRQ_REQ;
   wire [7:0] clr = ack_go ? (8'h01 << sel_idx) : 8'h00;
   wire [7:0] pend = {extra_external_irq_control[`ITC_XC_XINT3_FLAG],
      extra_external_irq_control[`ITC_XC_XINT2_FLAG],
      TIMER2_OVERFLOW_FLAG || TIMER2_CAPTURE_RELOAD_FLAG,
      SERIAL_REQ,
      timer_control[`ITC_TC_T1_OVF], timer_control[`ITC_TC_XINT1_FLAG],
      timer_control[`ITC_TC_T0_OVF], timer_control[`ITC_TC_XINT0_FLAG]};
   wire [7:0] src_en = {extra_external_irq_control[`ITC_XC_XINT3_EN],
      extra_external_irq_control[`ITC_XC_XINT2_EN], interrupt_enable[5:0]};
   wire [7:0] src_high = {extra_external_irq_control[`ITC_XC_XINT3_HIGH],
      extra_external_irq_control[`ITC_XC_XINT2_HIGH], interrupt_priority[5:0]};
   wire [7:0] act = pend & src_en & {8{interrupt_enable[`ITC_IE_GLOBAL]}};
   wire [3:0] pick_hi = itc_first(act & src_high);
   wire [3:0] pick_lo = itc_first(act & ~src_high);
   reg next_req;
   reg next_high;
   reg [2:0] next_idx;
   always @* begin
      next_req = 1'b0;
      next_high = sel_high;
      next_idx = sel_idx;
      if (pick_hi[3] && !in_service[1]) begin
         next_req = 1'b1;
         next_high = 1'b1;
         next_idx = pick_hi[2:0];
      end else if (pick_lo[3] && in_service == 2'b00) begin
         next_req = 1'b1;
         next_high = 1'b0;
         next_idx = pick_lo[2:0];
      end
      // A request just taken is withdrawn until its flag has cleared.
      if (ack_go) begin
         next_req = 1'b0;
      end
   end

   reg [1:0] next_ins;
   always @* begin
      next_ins = in_service;
      if (IRQ_RETURN) begin
         if (next_ins[1]) begin
            next_ins[1] = 1'b0;
         end else begin
            next_ins[0] = 1'b0;
         end
      end
      if (ack_go) begin
         next_ins[sel_high] = 1'b1;
      end
   end

   // ============================================================
   // Control registers with hardware-owned flags.
   wire wr_tc = wr && (reg_idx == `ITC_IDX_TIMER_CONTROL);
   wire wr_xc = wr && (reg_idx == `ITC_IDX_XIRQ_CONTROL);
   reg [7:0] next_tc;
   reg [7:0] next_xc;
   always @* begin
      next_tc = wr_tc ? wd : timer_control;
      next_xc = wr_xc ? wd : extra_external_irq_control;
      next_tc[`ITC_TC_XINT0_FLAG] = itc_flag(timer_control[`ITC_TC_XINT0_FLAG],
         timer_control[`ITC_TC_XINT0_TYPE], pin_fall[0], !pin_f[0], wr_tc,
         wd[`ITC_TC_XINT0_FLAG], clr[0]);
      next_tc[`ITC_TC_T0_OVF] = itc_flag(timer_control[`ITC_TC_T0_OVF], 1'b1, ovf0,
         1'b0, wr_tc, wd[`ITC_TC_T0_OVF], clr[1]);
      next_tc[`ITC_TC_XINT1_FLAG] = itc_flag(timer_control[`ITC_TC_XINT1_FLAG],
         timer_control[`ITC_TC_XINT1_TYPE], pin_fall[1], !pin_f[1], wr_tc,
         wd[`ITC_TC_XINT1_FLAG], clr[2]);
      next_tc[`ITC_TC_T1_OVF] = itc_flag(timer_control[`ITC_TC_T1_OVF], 1'b1, ovf1,
         1'b0, wr_tc, wd[`ITC_TC_T1_OVF], clr[3]);
      next_xc[`ITC_XC_XINT2_FLAG] = itc_flag(extra_external_irq_control[`ITC_XC_XINT2_FLAG],
         extra_external_irq_control[`ITC_XC_XINT2_TYPE], pin_fall[2], !pin_f[2], wr_xc,
         wd[`ITC_XC_XINT2_FLAG], clr[6]);
      next_xc[`ITC_XC_XINT3_FLAG] = itc_flag(extra_external_irq_control[`ITC_XC_XINT3_FLAG],
         extra_external_irq_control[`ITC_XC_XINT3_TYPE], pin_fall[3], !pin_f[3], wr_xc,
         wd[`ITC_XC_XINT3_FLAG], clr[7]);
   end

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         timer_control <= `ITC_RST_BYTE;
         timer_mode <= `ITC_RST_BYTE;
         interrupt_enable <= `ITC_RST_BYTE;
         interrupt_priority <= `ITC_RST_BYTE;
         extra_external_irq_control <= `ITC_RST_BYTE;
         timer0_low_byte <= `ITC_RST_BYTE;
         timer0_high_byte <= `ITC_RST_BYTE;
         timer1_low_byte <= `ITC_RST_BYTE;
         timer1_high_byte <= `ITC_RST_BYTE;
         in_service <= 2'b00;
         sel_idx <= 3'h0;
         sel_high <= 1'b0;
         IRQ_REQ <= 1'b0;
         IRQ_VECTOR <= `ITC_VECTOR_BASE;
      end else begin
         timer_control <= next_tc;
         extra_external_irq_control <= next_xc;
         if (wr && reg_idx == `ITC_IDX_TIMER_MODE) begin
            timer_mode <= wd;
         end
         if (wr && reg_idx == `ITC_IDX_IRQ_ENABLE) begin
            interrupt_enable <= wd & 8'hBF;
         end
         if (wr && reg_idx == `ITC_IDX_IRQ_PRIORITY) begin
            interrupt_priority <= wd & 8'h3F;
         end
         timer0_low_byte <= next_tl0;
         timer0_high_byte <= next_th0;
         timer1_low_byte <= next_tl1;
         timer1_high_byte <= next_th1;
         in_service <= next_ins;
         sel_idx <= next_idx;
         sel_high <= next_high;
         IRQ_REQ <= next_req;
         IRQ_VECTOR <= {2'b00, next_idx, 3'b000} + `ITC_VECTOR_BASE;
      end
   end

endmodule // itc_irq_ctrl
`default_nettype wire

// File: verif/itc_irq_ctrl_properties.sv
// Concurrent checks on the interrupt controller ports.
`timescale 1ns/1ps
`default_nettype none
`include "itc_consts.vh"
// ============================================================
// Checker
module itc_irq_ctrl_chk #(
   parameter [7:0] MCYCLE_CLKS = `ITC_MCYCLE_CLKS
) (
   input wire REF_CLK,
   input wire RST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR,
   input wire XINT0_PIN,
   input wire XINT1_PIN,
   input wire XINT2_PIN,
   input wire XINT3_PIN,
   input wire T0_COUNT_PIN,
   input wire T1_COUNT_PIN,
   input wire SERIAL_REQ,
   input wire TIMER2_OVERFLOW_FLAG,
   input wire TIMER2_CAPTURE_RELOAD_FLAG,
   input wire IRQ_REQ,
   input wire [7:0] IRQ_VECTOR,
   input wire IRQ_ACK,
   input wire IRQ_RETURN
);
   wire [11:0] ie_addr = {2'h0, `ITC_IDX_IRQ_ENABLE, 2'h0};
   wire acc = PSEL && PENABLE;
   reg ge;
   reg [2:0] off;
   // The master enable is shadowed from bus writes; three quiet cycles cover the request latency.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ge <= 1'h0;
         off <= 3'h0;
      end else begin
         if (acc && PWRITE && PADDR == ie_addr)
            ge <= PWDATA[`ITC_IE_GLOBAL];
         off <= {off[1:0], !ge};
      end
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   chk_ready_high: assert property (acc |-> PREADY) else $error("no ready in access");
   chk_err_misalign: assert property (acc && PADDR[1:0] != 2'h0 |-> PSLVERR)
      else $error("misaligned access not refused");
   chk_err_idle: assert property (!acc |-> !PSLVERR) else $error("error outside access");
   chk_err_mapped: assert property (acc && PADDR == ie_addr |-> !PSLVERR)
      else $error("mapped access refused");
   chk_rdata_upper: assert property (PRDATA[31:8] == 24'h0) else $error("read data upper set");
   chk_rdata_holds: assert property (acc |=> $stable(PRDATA)) else $error("read data moved");
   chk_vector_form:
      assert property (IRQ_REQ |-> IRQ_VECTOR[2:0] == 3'h3 && IRQ_VECTOR[7:6] == 2'h0)
      else $error("bad vector");
   chk_ack_drops:
      assert property (IRQ_ACK && IRQ_REQ |=> !IRQ_REQ) else $error("request kept after ack");
   chk_global_mask:
      assert property (&off |-> !IRQ_REQ) else $error("request while masked");
   cov_ack: cover property (IRQ_ACK && IRQ_REQ);
   cov_refused: cover property (acc && PSLVERR);
   cov_return: cover property (IRQ_RETURN ##2 IRQ_REQ);
endmodule // itc_irq_ctrl_chk

bind itc_irq_ctrl itc_irq_ctrl_chk #(.MCYCLE_CLKS(MCYCLE_CLKS)) itc_irq_ctrl_chk_inst (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .XINT0_PIN(XINT0_PIN), .XINT1_PIN(XINT1_PIN), .XINT2_PIN(XINT2_PIN),
   .XINT3_PIN(XINT3_PIN), .T0_COUNT_PIN(T0_COUNT_PIN), .T1_COUNT_PIN(T1_COUNT_PIN),
   .SERIAL_REQ(SERIAL_REQ), .TIMER2_OVERFLOW_FLAG(TIMER2_OVERFLOW_FLAG),
   .TIMER2_CAPTURE_RELOAD_FLAG(TIMER2_CAPTURE_RELOAD_FLAG), .IRQ_REQ(IRQ_REQ),
   .IRQ_VECTOR(IRQ_VECTOR), .IRQ_ACK(IRQ_ACK), .IRQ_RETURN(IRQ_RETURN));
`default_nettype wire

// File: verif/itc_cpu_model.sv
// Behavioural CPU core that takes presented interrupts and returns from them.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// CPU model
module itc_cpu_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic irq_req,
   input wire logic slow,
   output logic irq_ack,
   output logic irq_return
);
   // The model never nests routines, so preemption is not exercised through it.
   initial begin
      irq_ack = 1'h0;
      irq_return = 1'h0;
      forever begin
         @(posedge clk);
         if (rst_n && irq_req) begin
            if (slow)
               repeat (3) @(posedge clk);
            irq_ack <= 1'h1;
            @(posedge clk);
            irq_ack <= 1'h0;
            repeat (4) @(posedge clk);
            irq_return <= 1'h1;
            @(posedge clk);
            irq_return <= 1'h0;
         end
      end
   end
endmodule // itc_cpu_model
`default_nettype wire

// File: verif/itc_irq_ctrl_tb.sv
// Self-checking testbench for the interrupt controller with timers 0 and 1.
`timescale 1ns/1ps
`default_nettype none
`include "itc_consts.vh"
// ============================================================
// Bench
module itc_irq_ctrl_tb;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, cnt_pin, ser, t2o, t2c;
   logic ack, ret, req, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [3:0] xp;
   logic [7:0] vec;
   logic [7:0] regs [0:4] = '{`ITC_IDX_TIMER_CONTROL, `ITC_IDX_TIMER_MODE,
      `ITC_IDX_IRQ_ENABLE, `ITC_IDX_IRQ_PRIORITY, `ITC_IDX_XIRQ_CONTROL};
   logic [32:0] rd_q[$];
   logic [7:0] vec_q[$];
   integer bad_count, total_checks, seed, i;

   itc_irq_ctrl #(.MCYCLE_CLKS(8'h02)) itc_irq_ctrl_inst (.REF_CLK(clk), .RST_N(rst_n),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .XINT0_PIN(xp[0]),
      .XINT1_PIN(xp[1]), .XINT2_PIN(xp[2]), .XINT3_PIN(xp[3]), .T0_COUNT_PIN(cnt_pin),
      .T1_COUNT_PIN(cnt_pin), .SERIAL_REQ(ser), .TIMER2_OVERFLOW_FLAG(t2o),
      .TIMER2_CAPTURE_RELOAD_FLAG(t2c), .IRQ_REQ(req), .IRQ_VECTOR(vec), .IRQ_ACK(ack),
      .IRQ_RETURN(ret));
   itc_cpu_model itc_cpu_model_inst (.clk(clk), .rst_n(rst_n), .irq_req(req), .slow(slow),
      .irq_ack(ack), .irq_return(ret));

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // A read notes its expected {error, data} before its setup cycle starts.
   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
      input logic [32:0] e);
      if (!w)
         rd_q.push_back(e);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1)
         @(posedge clk);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb({2'h0, idx, 2'h0}, 1'h1, d, 33'h0);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      apb({2'h0, idx, 2'h0}, 1'h0, 8'h00, {25'h0, e});
   endtask

   task automatic drain;
      integer n;
      n = 0;
      while (vec_q.size() != 0 && n < 2000) begin
         n = n + 1;
         @(posedge clk);
      end
      chk({1'b0, vec_q.size()}, 33'h0);
   endtask

   // Results arrive as completed reads and taken interrupts; the routine clears its level source.
   always @(posedge clk) begin
      if (rst_n && psel && penable && pready === 1'h1 && !pwrite)
         chk({pslverr, prdata}, rd_q.size() ? rd_q.pop_front() : 33'h0FFFFFFFF);
      if (rst_n && ack && req === 1'h1) begin
         chk({25'h0, vec}, {25'h0, vec_q.size() ? vec_q.pop_front() : 8'hFF});
         if (vec == 8'h23)
            ser <= 1'h0;
         if (vec == 8'h2B) begin
            t2o <= 1'h0;
            t2c <= 1'h0;
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      bad_count = bad_count + 1;
      $display("BAD %0t run did not finish", $time);
      results;
   end

   initial begin
      seed = 32'hC12D387F;
      bad_count = 0;
      total_checks = 0;
      {rst_n, psel, penable, pwrite, ser, t2o, t2c, slow} = 8'h00;
      cnt_pin = 1'h1;
      xp = 4'hF;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      for (i = 0; i < 5; i = i + 1)
         rd(regs[i], `ITC_RST_BYTE);
      for (i = 0; i < 4; i = i + 1) begin
         rv = $random(seed);
         wr(`ITC_IDX_IRQ_PRIORITY, rv[7:0]);
         rd(`ITC_IDX_IRQ_PRIORITY, rv[7:0] & 8'h3F);
         wr(`ITC_IDX_IRQ_ENABLE, rv[15:8]);
         rd(`ITC_IDX_IRQ_ENABLE, rv[15:8] & 8'hBF);
         wr(`ITC_IDX_TIMER_MODE, rv[23:16]);
         rd(`ITC_IDX_TIMER_MODE, rv[23:16]);
      end
      apb(12'h004, 1'h0, 8'h00, 33'h100000000);
      apb(12'h2A1, 1'h0, 8'h00, 33'h100000000);
      // All eight sources pend while masked, then are taken in polling order.
      wr(`ITC_IDX_IRQ_PRIORITY, 8'h00);
      wr(`ITC_IDX_IRQ_ENABLE, 8'h3F);
      wr(`ITC_IDX_TIMER_MODE, 8'h11);
      for (i = 0; i < 4; i = i + 1)
         wr(`ITC_IDX_TIMER0_LOW + i[7:0], 8'hFF);
      wr(`ITC_IDX_XIRQ_CONTROL, 8'h55);
      wr(`ITC_IDX_TIMER_CONTROL, 8'h55);
      xp <= 4'h0;
      ser <= 1'h1;
      t2c <= 1'h1;
      repeat (30) @(posedge clk);
      for (i = 0; i < 8; i = i + 1)
         vec_q.push_back(8'h03 + 8'h08 * i[7:0]);
      wr(`ITC_IDX_IRQ_ENABLE, 8'hBF);
      drain;
      rd(`ITC_IDX_TIMER_CONTROL, 8'h55);
      rd(`ITC_IDX_XIRQ_CONTROL, 8'h55);
      // High level first, polled within the level, with a slow core.
      wr(`ITC_IDX_IRQ_ENABLE, 8'h3F);
      xp <= 4'hF;
      repeat (10) @(posedge clk);
      wr(`ITC_IDX_IRQ_PRIORITY, 8'h20);
      wr(`ITC_IDX_XIRQ_CONTROL, 8'hD5);
      xp <= 4'h6;
      t2o <= 1'h1;
      slow <= 1'h1;
      repeat (30) @(posedge clk);
      vec_q.push_back(8'h2B);
      vec_q.push_back(8'h3B);
      vec_q.push_back(8'h03);
      wr(`ITC_IDX_IRQ_ENABLE, 8'hBF);
      drain;
      // Level mode follows the pin and is not latched.
      wr(`ITC_IDX_IRQ_ENABLE, 8'h00);
      wr(`ITC_IDX_XIRQ_CONTROL, 8'h04);
      xp <= 4'hB;
      repeat (10) @(posedge clk);
      rd(`ITC_IDX_XIRQ_CONTROL, 8'h06);
      xp <= 4'hF;
      repeat (10) @(posedge clk);
      rd(`ITC_IDX_XIRQ_CONTROL, 8'h04);
      // Timer 0 counts pin falls with auto-reload; timer 1 is parked in mode 11.
      wr(`ITC_IDX_TIMER_MODE, 8'h36);
      wr(`ITC_IDX_TIMER0_LOW, 8'hFE);
      wr(`ITC_IDX_TIMER0_HIGH, 8'hFE);
      wr(`ITC_IDX_TIMER_CONTROL, 8'h50);
      for (i = 0; i < 3; i = i + 1) begin
         cnt_pin <= 1'h0;
         repeat (6) @(posedge clk);
         cnt_pin <= 1'h1;
         repeat (6) @(posedge clk);
      end
      rd(`ITC_IDX_TIMER0_LOW, 8'hFF);
      rd(`ITC_IDX_TIMER0_HIGH, 8'hFE);
      rd(`ITC_IDX_TIMER_CONTROL, 8'h70);
      rd(`ITC_IDX_IRQ_STATUS, 8'h00);
      // With the gate set and its pin low, a pin fall must not count.
      xp <= 4'hE;
      wr(`ITC_IDX_TIMER_MODE, 8'h3E);
      cnt_pin <= 1'h0;
      repeat (6) @(posedge clk);
      cnt_pin <= 1'h1;
      repeat (6) @(posedge clk);
      rd(`ITC_IDX_TIMER0_LOW, 8'hFF);
      results;
   end
endmodule // itc_irq_ctrl_tb
`default_nettype wire
